// [include/ccmc_pkg.sv]
// Constants, field layout and state types for the configuration and mode control block.
package ccmc_pkg;
  localparam int NREG = 13;
  localparam int RW = 16;
  localparam int TW = 20;
  // ==========================================================================
  // Register indices and field positions.
  localparam logic [3:0] R_DIV0 = 4'h0;
  localparam logic [3:0] R_DIV0_FH = 4'h1;
  localparam logic [3:0] R_DIV0_FL = 4'h2;
  localparam logic [3:0] R_DIV1 = 4'h3;
  localparam logic [3:0] R_SPREAD = 4'h4;
  localparam logic [3:0] R_DIV1_FH = 4'h6;
  localparam logic [3:0] R_OUTS = 4'h7;
  localparam logic [3:0] R_DIV1_FL = 4'h8;
  localparam logic [3:0] R_SPTYPE = 4'h9;
  localparam logic [3:0] R_CTRL = 4'ha;
  localparam logic [3:0] R_ADDR = 4'hc;
  localparam int INT_W = 7;
  localparam int DIV0_INT_LSB = 3;
  localparam int DIV1_INT_LSB = 9;
  localparam int FRAC_HI_W = 8;
  localparam int DIV0_FH_LSB = 8;
  localparam int DIV1_FH_LSB = 5;
  localparam int CH0_SEL_BIT = 4;
  localparam int CH1_SEL_BIT = 5;
  localparam int CHE_SEL_BIT = 6;
  localparam int SPREAD_EN_BIT = 0;
  localparam int OE_ONE_BIT = 0;
  localparam int OE_TWO_BIT = 1;
  localparam int POWER_DOWN_BIT = 1;
  localparam int AUTOLOAD_DIS_BIT = 2;
  localparam int RESAMPLE_DIS_BIT = 3;
  localparam int IDLE_SEL_BIT = 4;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_W = 7;
  localparam int ADDR_LSB_SEL_BIT = 15;
  localparam logic [6:0] INT_MIN = 7'h06;
  localparam logic [6:0] INT_MAX = 7'h18;
  // Bits that may differ between pages; all other bits come from page 0.
  localparam logic [RW-1:0] MASK_SPREAD = 16'h0001;
  localparam logic [RW-1:0] MASK_OUTS = 16'h00ff;
  localparam logic [RW-1:0] MASK_SPTYPE = 16'h0e00;
  // ==========================================================================
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int WIN_US = 350;
  localparam int WIN_CYC = WIN_US * CLK_MHZ;
  localparam real RELOAD_MS = 1.5;
  localparam int RELOAD_CYC = int'(RELOAD_MS * 1000.0 * CLK_MHZ);
  // ==========================================================================
  // State types.
  typedef enum logic [2:0] {ST_CAPT, ST_LOAD, ST_RUN, ST_LP, ST_SELW} ccmc_state_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_HI, I_LO} ccmc_i2c_t;
endpackage : ccmc_pkg

// [rtl/ccmc_core.sv]
// Mode selection, page loading, low-power handling and serial register access.
// How it works
// RL1: Strap sampled high at start-up selects fused-page mode.
// RL2: Strap sampled low at start-up selects serial configuration mode.
// RL3: In fused-page mode the two select pins choose which page loads.
// RL4: Mode changes need a new strap level plus a full power cycle; code also changes mode on wake resampling and on select-window expiry.
// RL5: After a select change, strap must rise within 350 us, else serial mode.
// RL6: A select change reloads the new page well within 1.5 ms.
// RL7: In serial mode the select pins are clock and data; host writes registers.
// RL8: Host rewrites its own settings after every power cycle; they are not kept.
// RL9: Power-down bit set enters low power; clearing it leaves low power.
// RL10: Idle-select zero with both output pairs disabled also enters low power.
// RL11: Host enters low power before changing divider, spread or format settings.
// RL12: Unless resampling is disabled, wake-up resamples pins and may enter fused mode.
// RL13: Resampling disabled: wake reloads page 0 unless autoload is disabled.
// RL14: Serial mode starts from page 0; fused mode from the selected page.
// RL15: Fused-page mode keeps the serial port off and ignores the address pin.
// RL16: Only spread, output enables, formats and spread type differ per page.
// RL17: Address upper bits from register 12; address pin gives 0x68 to 0x6B.
// RL18: Address low-bit select zero ignores the pin and uses the register field.
// RL19: Serial port enable follows the strap latched at start-up, not live level.
// RL20: Host reconfigures by setting power-down, writing, then clearing power-down.
// RL21: Second divider runs only when some channel selects it; spread only on first.
// RL22: Divider fields: first integer R0[9:3], second R3[15:9], fraction high R6[12:5].
// RL23: First divider integer is 7 bits, legal 6 to 24; fraction is 24 bits.
// RL24: Outputs and serial port stay inactive until the selected load completes.
`timescale 1ns/10ps
`default_nettype none
module ccmc_core
  import ccmc_pkg::*;
#(
  parameter logic [4*NREG*RW-1:0] FUSE_IMG     = '0,
  parameter int unsigned          WIN_CYC_P    = WIN_CYC,
  parameter int unsigned          RELOAD_CYC_P = RELOAD_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               mode_strap_pin,
  input  wire logic               page_select_low_pin,
  input  wire logic               page_select_high_pin_i,
  output logic                    page_select_high_pin_o,
  output logic                    page_select_high_pin_oe,
  input  wire logic               addr_select_pin,
  output logic                    i2c_mode_q,
  output logic                    low_power_q,
  output logic                    clock_outputs_on_q,
  output logic                    loading_q,
  output logic                    second_divider_enable_q,
  output logic                    spread_active_q,
  output logic                    first_int_legal_q,
  output logic [INT_W-1:0]        first_div_int,
  output logic [FRAC_HI_W+RW-1:0] first_div_frac,
  output logic [INT_W-1:0]        second_div_int,
  output logic [FRAC_HI_W+RW-1:0] second_div_frac,
  output logic [NREG*RW-1:0]      active_regs_q
);
  // ==========================================================================
  // Pin synchronisers: bit 0 clock, 1 data, 2 strap, 3 address.
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic [3:0] pin_p_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_m_q <= 4'h0;
      pin_s_q <= 4'h0;
      pin_p_q <= 4'h0;
    end else begin
      pin_m_q <= {addr_select_pin, mode_strap_pin, page_select_high_pin_i, page_select_low_pin};
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end
  logic       scl;
  logic       sda;
  logic       strap;
  logic       addr;
  logic [1:0] sel_live;
  assign scl = pin_s_q[0];
  assign sda = pin_s_q[1];
  assign strap = pin_s_q[2];
  assign addr = pin_s_q[3];
  assign sel_live = pin_s_q[1:0];
  // ==========================================================================
  // Control fields of the active registers.
  logic [RW-1:0] ctrl;
  logic [RW-1:0] outs;
  logic [RW-1:0] arg;
  logic          lp_req;
  assign ctrl = active_regs_q[R_CTRL*RW +: RW];
  assign outs = active_regs_q[R_OUTS*RW +: RW];
  assign arg = active_regs_q[R_ADDR*RW +: RW];
  assign lp_req = ctrl[POWER_DOWN_BIT] | (!ctrl[IDLE_SEL_BIT] & !outs[OE_ONE_BIT]
                  & !outs[OE_TWO_BIT]); // RL9 RL10
  // ==========================================================================
  // Mode and load sequencer.
  ccmc_state_t state_q;
  logic        mode_i2c_q;
  logic        wake_q;
  logic [1:0]  sel_cap_q;
  logic [1:0]  page_q;
  logic [3:0]  idx_q;
  logic [TW-1:0] timer_q;
  logic        strap_rise;
  logic        cap_go;
  logic        host_busy;
  assign strap_rise = strap & !pin_p_q[2];
  assign cap_go = state_q == ST_CAPT && idx_q == 4'h2;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_CAPT;
      mode_i2c_q <= 1'b0;
      wake_q <= 1'b0;
      sel_cap_q <= 2'h0;
      page_q <= 2'h0;
      idx_q <= 4'h0;
      timer_q <= '0;
    end else begin
      case (state_q)
        ST_CAPT: begin
          // Waits until the pin synchronisers hold real pin levels, not reset zeros.
          idx_q <= cap_go ? 4'h0 : idx_q + 4'h1;
          if (cap_go) begin
            mode_i2c_q <= !strap; // RL1 RL2 RL4 RL19
            sel_cap_q <= sel_live;
            page_q <= strap ? sel_live : 2'h0; // RL3 RL14
            wake_q <= 1'b0;
            if (wake_q && !strap && ctrl[AUTOLOAD_DIS_BIT]) begin
              state_q <= ST_RUN;
            end else begin
              state_q <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == 4'(NREG - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          timer_q <= '0;
          idx_q <= 4'h0;
          if (!mode_i2c_q && sel_live != sel_cap_q) begin
            state_q <= ST_SELW; // RL6
          end else if (lp_req) begin
            state_q <= ST_LP; // RL9 RL10
          end
        end
        ST_SELW: begin
          timer_q <= timer_q + 1'b1;
          if (strap_rise) begin
            state_q <= ST_CAPT; // RL5 RL6
          end else if (timer_q == TW'(WIN_CYC_P - 1)) begin
            mode_i2c_q <= 1'b1; // RL5
            page_q <= 2'h0;
            idx_q <= 4'h0;
            state_q <= ST_LOAD;
          end
        end
        ST_LP: begin
          if (!lp_req && !host_busy) begin
            if (!ctrl[RESAMPLE_DIS_BIT]) begin
              wake_q <= 1'b1; // RL12
              state_q <= ST_CAPT;
            end else if (!ctrl[AUTOLOAD_DIS_BIT]) begin
              page_q <= 2'h0; // RL13
              idx_q <= 4'h0;
              state_q <= ST_LOAD;
            end else begin
              state_q <= ST_RUN; // RL13
            end
          end
        end
        default: state_q <= ST_CAPT;
      endcase
    end
  end
  // ==========================================================================
  // Serial slave, write only: address, pointer, then 16-bit words.
  ccmc_i2c_t  ist_q;
  logic [3:0] bc_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic [7:0] hi_q;
  logic       adr_a_q;
  logic       adr_b_q;
  logic       en;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  logic       wr_now;
  logic [6:0] my_addr;
  assign en = mode_i2c_q && (state_q == ST_RUN || state_q == ST_LP); // RL7 RL15 RL24
  assign start = scl & pin_p_q[1] & !sda;
  assign stop = scl & !pin_p_q[1] & sda;
  assign rise = scl & !pin_p_q[0];
  assign fall = !scl & pin_p_q[0];
  assign wr_now = en && !start && !stop && ist_q == I_LO && fall && bc_q == 4'h8;
  assign host_busy = ist_q != I_IDLE;
  assign my_addr = arg[ADDR_LSB_SEL_BIT] ? {arg[ADDR_LSB+2 +: 5], adr_a_q ^ adr_b_q, adr_a_q}
                                         : arg[ADDR_LSB +: ADDR_W]; // RL17 RL18
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      adr_a_q <= 1'b0;
      adr_b_q <= 1'b0;
    end else if (en) begin
      if (start) begin
        adr_a_q <= addr; // RL17
      end
      if (!scl && sda) begin
        adr_b_q <= addr; // RL17
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ist_q <= I_IDLE;
      bc_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      hi_q <= 8'h00;
      page_select_high_pin_oe <= 1'b0;
    end else if (!en || stop) begin
      ist_q <= I_IDLE; // RL15
      page_select_high_pin_oe <= 1'b0;
    end else if (start) begin
      ist_q <= I_ADDR;
      bc_q <= 4'h0;
      page_select_high_pin_oe <= 1'b0;
    end else if (ist_q != I_IDLE) begin
      if (rise) begin
        bc_q <= bc_q + 4'h1;
        if (bc_q < 4'h8) begin
          sh_q <= {sh_q[6:0], sda};
        end
      end else if (fall && bc_q == 4'h8) begin
        page_select_high_pin_oe <= 1'b1;
        case (ist_q)
          I_ADDR: begin
            if (sh_q[7:1] != my_addr || sh_q[0]) begin
              page_select_high_pin_oe <= 1'b0;
              ist_q <= I_IDLE;
            end
          end
          I_PTR: ptr_q <= sh_q;
          I_HI: hi_q <= sh_q;
          I_LO: ptr_q <= ptr_q + 8'h01; // RL7
          default: ist_q <= I_IDLE;
        endcase
      end else if (fall && bc_q == 4'h9) begin
        page_select_high_pin_oe <= 1'b0;
        bc_q <= 4'h0;
        case (ist_q)
          I_ADDR: ist_q <= I_PTR;
          I_PTR: ist_q <= I_HI;
          I_HI: ist_q <= I_LO;
          I_LO: ist_q <= I_HI;
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_select_high_pin_o <= 1'b0;
    end else begin
      page_select_high_pin_o <= 1'b0;
    end
  end
  // ==========================================================================
  // Active registers: page load or serial write.
  logic [RW-1:0] fz;
  logic [RW-1:0] fp;
  logic [RW-1:0] pmask;
  assign fz = FUSE_IMG[idx_q*RW +: RW];
  assign fp = FUSE_IMG[(page_q*NREG+idx_q)*RW +: RW];
  always_comb begin
    case (idx_q)
      R_SPREAD: pmask = MASK_SPREAD;
      R_OUTS: pmask = MASK_OUTS;
      R_SPTYPE: pmask = MASK_SPTYPE;
      default: pmask = '0;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_regs_q <= '0;
    end else if (state_q == ST_LOAD) begin
      active_regs_q[idx_q*RW +: RW] <= (fz & ~pmask) | (fp & pmask); // RL16 RL3 RL14
    end else if (wr_now && ptr_q < 8'(NREG)) begin
      active_regs_q[ptr_q[3:0]*RW +: RW] <= {hi_q, sh_q}; // RL7
    end
  end
  assign first_div_int = active_regs_q[R_DIV0*RW+DIV0_INT_LSB +: INT_W]; // RL22 RL23
  assign first_div_frac = {active_regs_q[R_DIV0_FH*RW+DIV0_FH_LSB +: FRAC_HI_W],
                           active_regs_q[R_DIV0_FL*RW +: RW]};
  assign second_div_int = active_regs_q[R_DIV1*RW+DIV1_INT_LSB +: INT_W]; // RL22
  assign second_div_frac = {active_regs_q[R_DIV1_FH*RW+DIV1_FH_LSB +: FRAC_HI_W],
                            active_regs_q[R_DIV1_FL*RW +: RW]};
  // ==========================================================================
  // Status outputs.
  logic [RW-1:0] srcs;
  logic          on_d;
  assign srcs = active_regs_q[R_DIV1*RW +: RW];
  assign on_d = state_q == ST_RUN || state_q == ST_SELW;
  assign i2c_mode_q = mode_i2c_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_power_q <= 1'b0;
      clock_outputs_on_q <= 1'b0;
      loading_q <= 1'b1;
      second_divider_enable_q <= 1'b0;
      spread_active_q <= 1'b0;
      first_int_legal_q <= 1'b0;
    end else begin
      low_power_q <= state_q == ST_LP;
      clock_outputs_on_q <= on_d; // RL24
      loading_q <= state_q == ST_CAPT || state_q == ST_LOAD;
      second_divider_enable_q <= on_d && (srcs[CH0_SEL_BIT] | srcs[CH1_SEL_BIT]
                                          | srcs[CHE_SEL_BIT]); // RL21
      spread_active_q <= on_d && active_regs_q[R_SPREAD*RW+SPREAD_EN_BIT]; // RL21
      first_int_legal_q <= first_div_int >= INT_MIN && first_div_int <= INT_MAX; // RL23
    end
  end
  // ==========================================================================
  // Checks.
  logic [TW-1:0] rl_cnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rl_cnt_q <= '0;
    end else if (state_q == ST_RUN || state_q == ST_LP) begin
      rl_cnt_q <= '0;
    end else if (rl_cnt_q != '1) begin
      rl_cnt_q <= rl_cnt_q + 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence lp_exit_s;
    state_q == ST_LP && !lp_req && !host_busy;
  endsequence
  sequence win_expire_s;
    state_q == ST_SELW && !strap_rise && timer_q == TW'(WIN_CYC_P - 1);
  endsequence
  strap_high_a: assert property (cap_go && strap |=> !mode_i2c_q) // RL1
    else $error("Strap high did not select fused mode.");
  strap_low_a: assert property (cap_go && !strap |=> mode_i2c_q && page_q == 2'h0) // RL2
    else $error("Strap low did not select serial mode from page zero.");
  page_pick_a: assert property (cap_go && strap |=> page_q == $past(sel_live)) // RL3
    else $error("Wrong page chosen from select pins.");
  win_fall_a: assert property (win_expire_s |=> mode_i2c_q && state_q == ST_LOAD) // RL5
    else $error("Missed strap window did not fall into serial mode.");
  reload_time_a: assert property (rl_cnt_q < TW'(RELOAD_CYC_P)) // RL6
    else $error("Page reload took too long.");
  fused_quiet_a: assert property (!mode_i2c_q |-> !page_select_high_pin_oe) // RL15
    else $error("Serial port drove data in fused mode.");
  lp_enter_a: assert property (state_q == ST_RUN && mode_i2c_q && lp_req |=> // RL9
    low_power_q == 1'b0 ##1 low_power_q)
    else $error("Low power not entered.");
  resample_a: assert property (lp_exit_s ##0 !ctrl[RESAMPLE_DIS_BIT] |=> state_q == ST_CAPT) // RL12
    else $error("Wake did not resample the pins.");
  autoload_a: assert property (lp_exit_s ##0 ctrl[RESAMPLE_DIS_BIT] |=> // RL13
    (ctrl[AUTOLOAD_DIS_BIT] ? state_q == ST_RUN : state_q == ST_LOAD && page_q == 2'h0))
    else $error("Wrong wake action with resampling disabled.");
  load_quiet_a: assert property (state_q == ST_LOAD |=> !clock_outputs_on_q && loading_q) // RL24
    else $error("Outputs active during load.");
endmodule : ccmc_core
`default_nettype wire

// [dv/ccmc_host.sv]
// Serial host model that drives the shared clock and data pins of the block.
`timescale 1ns/10ps
`default_nettype none
module ccmc_host (
  input  wire logic dev_oe,
  output var logic  scl,
  output wire logic sda
);
  logic sda_q;
  // Open-drain data line with a pull-up; the device can only pull it low.
  assign sda = sda_q & ~dev_oe;
  initial begin
    scl = 1'b1;
    sda_q = 1'b1;
  end
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      sda_q = v[k];
      #16 scl = 1'b1;
      #32 scl = 1'b0;
      #16;
    end
    sda_q = 1'b1;
    #16 scl = 1'b1;
    #16 ack = ~sda;
    #16 scl = 1'b0;
    #16;
  endtask : put_byte
  // Address with write bit, pointer, then high byte before low byte.
  task automatic write_word(input logic [6:0] ad, input logic [7:0] pt,
                            input logic [15:0] v, output logic ack);
    logic a2;
    #1 sda_q = 1'b0;
    #16 scl = 1'b0;
    #16;
    put_byte({ad, 1'b0}, ack);
    put_byte(pt, a2);
    put_byte(v[15:8], a2);
    put_byte(v[7:0], a2);
    sda_q = 1'b0;
    #16 scl = 1'b1;
    #16 sda_q = 1'b1;
    #16;
  endtask : write_word
endmodule : ccmc_host
`default_nettype wire

// [dv/ccmc_core_tb.sv]
// Self-checking bench for the configuration and mode control block.
`timescale 1ns/10ps
`default_nettype none
module ccmc_core_tb import ccmc_pkg::*;;
  localparam int WIN = 40;
  localparam int RLD = 200;
  localparam int TBL [4] = '{5, 6, 24, 25};
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b0;
  logic bus = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [1:0] amode = 2'h0;
  logic [31:0] seed = 32'h0013;
  int fails = 0;
  int checked = 0;
  wire logic scl, sda, oe, i2c, lp, con, ld, sde, spa, legal, adp, pdo;
  wire logic [INT_W-1:0] fint, sint;
  wire logic [23:0] ffrac, sfrac;
  wire logic [NREG*RW-1:0] regs;
  // ==========================================================================
  // Expected page images.
  function automatic logic [RW-1:0] fw(int p, int i);
    if (i == 12) return 16'h6800;
    if (i == 10) return 16'h0010;
    return {4'(p * 3 + 1), 4'(i), 8'(p * 37 + i)};
  endfunction : fw
  function automatic logic [RW-1:0] ex(int p, int i);
    logic [RW-1:0] m;
    m = (i == 4) ? MASK_SPREAD : (i == 7) ? MASK_OUTS : (i == 9) ? MASK_SPTYPE : 16'h0000;
    return (fw(0, i) & ~m) | (fw(p, i) & m);
  endfunction : ex
  function automatic logic [4*NREG*RW-1:0] mk();
    logic [4*NREG*RW-1:0] f;
    for (int n = 0; n < 4 * NREG; n++) f[n*RW +: RW] = fw(n / NREG, n % NREG);
    return f;
  endfunction : mk
  localparam logic [4*NREG*RW-1:0] FUSE = mk();
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [RW-1:0] rg(int i);
    return regs[i*RW +: RW];
  endfunction : rg
  always #2 core_clk = ~core_clk;
  assign adp = amode == 2'h2 ? sda : amode == 2'h3 ? scl : amode[0];
  ccmc_host host (.dev_oe(oe), .scl(scl), .sda(sda));
  ccmc_core #(.FUSE_IMG(FUSE), .WIN_CYC_P(WIN), .RELOAD_CYC_P(RLD)) uut (
    .core_clk(core_clk), .resetn(resetn), .mode_strap_pin(strap),
    .page_select_low_pin(bus ? scl : sel[0]), .page_select_high_pin_i(bus ? sda : sel[1]),
    .page_select_high_pin_o(pdo), .page_select_high_pin_oe(oe), .addr_select_pin(adp),
    .i2c_mode_q(i2c), .low_power_q(lp), .clock_outputs_on_q(con), .loading_q(ld),
    .second_divider_enable_q(sde), .spread_active_q(spa), .first_int_legal_q(legal),
    .first_div_int(fint), .first_div_frac(ffrac), .second_div_int(sint),
    .second_div_frac(sfrac), .active_regs_q(regs));
  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic settle(int lim);
    int n;
    n = 0;
    repeat (6) @(posedge core_clk);
    while ((ld || lp || !con) && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("settle", n < lim, 1);
  endtask : settle
  task automatic rst(input logic s, input logic [1:0] p);
    bus <= ~s;
    resetn <= 1'b0;
    strap <= s;
    sel <= p;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("held", con, 0);
    settle(100);
  endtask : rst
  task automatic wr(input logic [6:0] ad, input logic [7:0] pt, input logic [15:0] v,
                    input logic ea);
    logic a;
    host.write_word(ad, pt, v, a);
    chk("ack", a, ea);
    repeat (4) @(posedge core_clk);
  endtask : wr
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    logic [15:0] v;
    logic [6:0] iv;
    for (int p = 0; p < 4; p++) begin
      amode <= 2'(p);
      rst(1'b1, 2'(p));
      chk("mode", i2c, 0);
      chk("oe", oe, 0);
      for (int i = 0; i < NREG; i++) chk("page", rg(i), ex(p, i));
    end
    strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    sel <= 2'h2;
    repeat (WIN / 2) @(posedge core_clk);
    strap <= 1'b1;
    settle(RLD);
    chk("dyn", rg(7), ex(2, 7));
    chk("dynm", i2c, 0);
    strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    sel <= 2'h1;
    repeat (WIN + 10) @(posedge core_clk);
    bus <= 1'b1;
    settle(RLD);
    chk("late", i2c, 1);
    chk("latep", rg(7), ex(0, 7));
    $display("test fused done");
    amode <= 2'h0;
    rst(1'b0, 2'h0);
    chk("i2c", i2c, 1);
    for (int i = 0; i < NREG; i++) chk("p0", rg(i), ex(0, i));
    strap <= 1'b1;
    wr(7'h68, 8'd7, 16'h0123, 1'b1);
    chk("live", i2c, 1);
    chk("w7", rg(7), 16'h0123);
    chk("pdo", pdo, 0);
    strap <= 1'b0;
    wr(7'h68, 8'd12, 16'he800, 1'b1);
    for (int m = 0; m < 4; m++) begin
      amode <= 2'(m);
      v = 16'(rnd()) | 16'h0003;
      wr(7'h68 | 7'(m), 8'd7, v, 1'b1);
      chk("adr", rg(7), v);
      wr(7'h68 | 7'(m ^ 1), 8'd7, 16'h0003, 1'b0);
    end
    amode <= 2'h1;
    wr(7'h69, 8'd12, 16'h6c00, 1'b1);
    wr(7'h69, 8'd7, 16'h0003, 1'b0);
    wr(7'h6c, 8'd7, 16'h0103, 1'b1);
    chk("r18", rg(7), 16'h0103);
    $display("test address done");
    for (int k = 0; k < 6; k++) begin
      v = 16'(rnd());
      iv = (k < 4) ? 7'(TBL[k]) : v[6:0];
      wr(7'h6c, 8'd0, {v[15:10], iv, v[2:0]}, 1'b1);
      chk("int0", fint, iv);
      chk("legal", legal, iv >= INT_MIN && iv <= INT_MAX);
      wr(7'h6c, 8'd3, (v & 16'hff8f) | (k[0] ? 16'h0020 : 16'h0000), 1'b1);
      chk("int1", sint, v[15:9]);
      chk("div1", sde, k[0]);
      wr(7'h6c, 8'd6, v, 1'b1);
      chk("frac1", sfrac[23:16], v[12:5]);
      wr(7'h6c, 8'h01, v, 1'b1);
      chk("frac0", ffrac[23:16], v[15:8]);
    end
    wr(7'h6c, 8'd4, 16'h0001, 1'b1);
    chk("spread", spa, 1);
    $display("test divider done");
    wr(7'h6c, 8'd10, 16'h001a, 1'b1);
    chk("lowpwr", lp, 1);
    wr(7'h6c, 8'd7, 16'h0203, 1'b1);
    wr(7'h6c, 8'd10, 16'h0018, 1'b1);
    settle(RLD);
    chk("auto", rg(7), ex(0, 7));
    wr(7'h68, 8'd10, 16'h001e, 1'b1);
    wr(7'h68, 8'd7, 16'h0303, 1'b1);
    wr(7'h68, 8'd10, 16'h001c, 1'b1);
    settle(RLD);
    chk("keep", rg(7), 16'h0303);
    wr(7'h68, 8'd10, 16'h0012, 1'b1);
    strap <= 1'b1;
    wr(7'h68, 8'd10, 16'h0010, 1'b1);
    settle(RLD);
    chk("resmp", i2c, 0);
    $display("test low power done");
    rst(1'b0, 2'h0);
    chk("lost", rg(7), ex(0, 7));
    wr(7'h68, 8'd10, 16'h0000, 1'b1);
    chk("idle1", lp, 0);
    wr(7'h68, 8'd7, 16'h0000, 1'b1);
    chk("idle0", lp, 1);
    $display("test idle done");
    end_sim();
  end
endmodule : ccmc_core_tb
`default_nettype wire
